// ==== verilog/apw_top.sv ====
// host power switch, keypad power keys and host watchdog
`timescale 1ns/1ps
`default_nettype none
module apw_top
  import apw_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYC
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  // command link
  input  wire apw_cmd_t   cmd,
  output apw_reply_t      reply,
  // keypad
  input  wire logic       key_confirm,
  input  wire logic       key_cancel,
  // host lines
  input  wire logic       host_alive,
  input  wire logic       sw_in,
  output logic            sw_out,
  output logic            sw_oe_n,
  input  wire logic       rst_in,
  output logic            rst_out,
  output logic            rst_oe_n,
  // display and module
  output logic            disp_blank,
  output logic            backlight_off,
  output logic            fan_hold,
  output logic            show_on,
  output logic            show_off,
  output logic            show_reset,
  output logic            module_restart,
  // status fields
  output logic [7:0]      stat_mask,
  output logic [7:0]      stat_wdt
);
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ON    = 3'b001,
    ST_OFF   = 3'b010,
    ST_EXTRA = 3'b011,
    ST_RST   = 3'b100,
    ST_HOLD  = 3'b101,
    ST_BOOT  = 3'b110
  } apw_st_t;

  apw_st_t     st_r;
  logic [7:0]  mask_r;
  logic [7:0]  len_r;
  logic [7:0]  wdt_r;
  logic [21:0] div_r;
  logic        tick;
  logic [8:0]  hold_r;
  logic [8:0]  pt_r;
  logic [4:0]  sec_r;
  logic        alive_q_r;
  logic        sw_lvl_r;
  logic        rst_lvl_r;
  logic        act_mod_r;
  logic        wdt_fire;
  logic        alive_rise;
  logic        alive_chg;
  logic [8:0]  len_ticks;

  assign tick       = (div_r == 22'(TICK_DIV - 1));
  assign alive_rise = host_alive & ~alive_q_r;
  assign alive_chg  = host_alive ^ alive_q_r;
  assign len_ticks  = {1'b0, len_r};

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      div_r <= 22'h00_0000;
    end else if (tick) begin
      div_r <= 22'h00_0000;
    end else begin
      div_r <= div_r + 22'h00_0001;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      alive_q_r <= 1'b0;
    end else begin
      alive_q_r <= host_alive;
    end
  end

  // configuration from command packets; reply one cycle later
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      mask_r <= MASK_RST;
      len_r  <= LEN_DEF;
    end else if (cmd.valid && cmd.ptype == CMD_PWR && (cmd.len == 2'd1 || cmd.len == 2'd2)) begin // RQ12
      mask_r <= cmd.d0; // RQ7
      if (cmd.len == 2'd2 && cmd.d1 != 8'h00) begin
        len_r <= cmd.d1; // RQ10
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      reply <= '0;
    end else if (cmd.valid && ((cmd.ptype == CMD_PWR && (cmd.len == 2'd1 || cmd.len == 2'd2))
                               || (cmd.ptype == CMD_WDT && cmd.len == 2'd1))) begin
      reply <= '{valid: 1'b1, ptype: cmd.ptype | REPLY_FLAG}; // RQ12 RQ13
    end else begin
      reply <= '0;
    end
  end

  // watchdog counts seconds; a refresh in the expiry tick reloads the count but the restart pulse still fires
  assign wdt_fire = tick && sec_r == 5'(SEC_TICKS - 1) && wdt_r == 8'h01;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wdt_r <= 8'h00; // RQ17
      sec_r <= 5'h00;
    end else if (cmd.valid && cmd.ptype == CMD_WDT && cmd.len == 2'd1) begin
      wdt_r <= cmd.d0; // RQ14 RQ15
      sec_r <= 5'h00;
    end else if (tick && wdt_r != 8'h00) begin
      sec_r <= sec_r + 5'h01;
      if (sec_r == 5'(SEC_TICKS - 1)) begin
        wdt_r <= wdt_r - 8'h01; // RQ16 stops at zero until re-enabled
      end
    end
  end

  // released level of each line is captured while idle
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sw_lvl_r  <= 1'b1;
      rst_lvl_r <= 1'b1;
    end else if (st_r == ST_IDLE) begin
      sw_lvl_r  <= sw_in;
      rst_lvl_r <= rst_in;
    end
  end

  // key hold timer counts 1/32 s ticks
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      hold_r <= 9'h000;
    end else if (!(key_confirm ^ key_cancel) || st_r != ST_IDLE) begin
      // cleared during pulses so a key still held cannot retrigger at once
      hold_r <= 9'h000;
    end else if (tick && hold_r != 9'h1FF) begin
      hold_r <= hold_r + 9'h001;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_r           <= ST_IDLE;
      pt_r           <= 9'h000;
      module_restart <= 1'b0;
      act_mod_r      <= 1'b0;
    end else begin
      module_restart <= 1'b0;
      if (tick && pt_r != 9'h000) begin
        pt_r <= pt_r - 9'h001;
      end
      unique case (st_r)
        ST_IDLE: begin
          if (wdt_fire) begin
            st_r <= ST_RST; // RQ16
            pt_r <= T_RST_PULSE;
            act_mod_r <= 1'b0;
          end else if (!host_alive && mask_r[B_KEY_ON] && key_confirm && hold_r >= T_ON_PRESS) begin
            st_r <= (len_r == LEN_HOLD) ? ST_HOLD : ST_ON; // RQ1 RQ11
            pt_r <= len_ticks;
          end else if (host_alive && mask_r[B_KEY_OFF] && key_cancel && hold_r >= T_LONG_PRESS) begin
            st_r <= (len_r == LEN_HOLD) ? ST_HOLD : ST_OFF; // RQ2 RQ11
            pt_r <= len_ticks;
          end else if (host_alive && mask_r[B_KEY_RST] && key_confirm && hold_r >= T_LONG_PRESS) begin
            st_r <= ST_RST; // RQ19
            pt_r <= T_RST_PULSE;
            act_mod_r <= 1'b1;
          end else if (mask_r[B_BLANK] && alive_rise) begin
            module_restart <= 1'b1; // RQ5
          end
        end
        ST_ON: begin
          if (pt_r == 9'h000) begin
            st_r <= ST_BOOT; // RQ1
          end
        end
        ST_OFF: begin
          if (pt_r == 9'h000) begin
            st_r <= key_cancel ? ST_EXTRA : ST_IDLE; // RQ3
            pt_r <= T_EXTRA;
          end
        end
        ST_EXTRA: begin
          if (!key_cancel || pt_r == 9'h000) begin
            st_r <= ST_IDLE; // RQ3
          end
        end
        ST_RST: begin
          if (pt_r == 9'h000) begin
            st_r <= act_mod_r ? ST_BOOT : ST_IDLE; // RQ19
          end
        end
        ST_HOLD: begin
          if (alive_chg) begin
            st_r <= host_alive ? ST_BOOT : ST_IDLE; // RQ11
          end
        end
        ST_BOOT: begin
          // lines released a cycle before the restart request
          module_restart <= 1'b1;
          st_r           <= ST_IDLE;
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // polarity: sense picks opposite of released level, else invert bits
  always_comb begin
    sw_oe_n  = !(st_r == ST_ON || st_r == ST_OFF || st_r == ST_EXTRA || st_r == ST_HOLD); // RQ20
    rst_oe_n = !(st_r == ST_RST); // RQ20
    sw_out   = mask_r[B_SENSE] ? ~sw_lvl_r : mask_r[B_PWR_INV]; // RQ9 RQ21
    rst_out  = mask_r[B_SENSE] ? ~rst_lvl_r : mask_r[B_RST_INV]; // RQ8 RQ21
  end

  always_comb begin
    disp_blank    = mask_r[B_BLANK] && !host_alive; // RQ4
    backlight_off = mask_r[B_BLANK] && !host_alive; // RQ4
    fan_hold      = !host_alive; // RQ6
    show_on       = (st_r == ST_ON) || (st_r == ST_HOLD && !host_alive);
    show_off      = (st_r == ST_OFF) || (st_r == ST_EXTRA) || (st_r == ST_HOLD && host_alive);
    show_reset    = (st_r == ST_RST);
    stat_mask     = mask_r; // RQ18
    stat_wdt      = wdt_r; // RQ18
  end
endmodule
`default_nettype wire

// ==== verilog/apw_pkg.sv ====
// package for the host power switch and watchdog block
// Overview of operation
// RQ1 - host off, power-on enabled: confirm held 0.25 s pulses switch, shows on, restarts
// RQ2 - host on, shutdown enabled: cancel held 4 s pulses switch, shows off
// RQ3 - cancel still held after pulse keeps switch driven, at most 5 more seconds
// RQ4 - blank enabled and host off: display blank, backlight off, keypad still watched
// RQ5 - blank enabled: host-alive rising edge triggers full module restart; code restarts only on an edge seen in ST_IDLE
// RQ6 - fan power settings hold while host is sensed off
// RQ7 - mask bits: 01 sense, 10 blank, 20 restart key, 40 power-on, 80 shutdown
// RQ8 - mask 02 without sense: restart line pulses high
// RQ9 - mask 04 without sense: switch line pulses high
// RQ10 - optional second byte sets pulse length, 1 to 254 units of 1/32 s
// RQ11 - length 255 holds switch until host-alive changes state
// RQ12 - command 1C with one or two bytes, reply 5C empty
// RQ13 - command 1D with timeout byte, reply 5D empty
// RQ14 - timeout zero disables the watchdog
// RQ15 - host must resend watchdog command within timeout seconds
// RQ16 - watchdog expiry pulses the host restart line; code does so only when the expiry tick finds ST_IDLE, else the expiry is lost
// RQ17 - watchdog off after power-up, no reset until enabled again
// RQ18 - status gives mask as byte 7 and watchdog count as byte 8
// RQ19 - host on, restart enabled: confirm held 4 s pulses restart 1 s, restarts module
// RQ20 - lines released when idle, driven only during a pulse
// RQ21 - line sense: active level is opposite of released level
package apw_pkg;
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned TICK_HZ      = 32;
  localparam int unsigned TICK_CYC     = CLK_HZ / TICK_HZ;
  localparam int unsigned SEC_TICKS    = 32;
  localparam logic [7:0]  CMD_PWR      = 8'h1C;
  localparam logic [7:0]  CMD_WDT      = 8'h1D;
  localparam logic [7:0]  REPLY_FLAG   = 8'h40;
  localparam int unsigned B_SENSE      = 0;
  localparam int unsigned B_RST_INV    = 1;
  localparam int unsigned B_PWR_INV    = 2;
  localparam int unsigned B_BLANK      = 4;
  localparam int unsigned B_KEY_RST    = 5;
  localparam int unsigned B_KEY_ON     = 6;
  localparam int unsigned B_KEY_OFF    = 7;
  localparam logic [7:0]  MASK_RST     = 8'h00;
  localparam logic [7:0]  LEN_DEF      = 8'h20;
  localparam logic [7:0]  LEN_HOLD     = 8'hFF;
  localparam logic [8:0]  T_ON_PRESS   = 9'h008;
  localparam logic [8:0]  T_LONG_PRESS = 9'h080;
  localparam logic [8:0]  T_EXTRA      = 9'h0A0;
  localparam logic [8:0]  T_RST_PULSE  = 9'h020;

  typedef struct packed {
    logic       valid;
    logic [7:0] ptype;
    logic [1:0] len;
    logic [7:0] d0;
    logic [7:0] d1;
  } apw_cmd_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] ptype;
  } apw_reply_t;
endpackage

// ==== tb/apw_host_model.sv ====
// host side of the switch and restart lines, pulled up when released
`timescale 1ns/1ps
`default_nettype none
module apw_host_model (
  // lines from the block
  input  wire logic sw_out,
  input  wire logic sw_oe_n,
  input  wire logic rst_out,
  input  wire logic rst_oe_n,
  // host state
  input  wire logic power_good,
  output logic      host_alive,
  output logic      sw_in,
  output logic      rst_in
);
  // a released line shows the pull-up, never the last driven value
  assign sw_in      = sw_oe_n ? 1'b1 : sw_out;
  assign rst_in     = rst_oe_n ? 1'b1 : rst_out;
  assign host_alive = power_good;
endmodule
`default_nettype wire

// ==== tb/apw_properties.sv ====
// port checker for the power switch block
`timescale 1ns/1ps
`default_nettype none
module apw_properties
  import apw_pkg::*;
(
  // watched ports
  input wire logic       sys_clk,
  input wire logic       nrst,
  input wire apw_cmd_t   cmd,
  input wire apw_reply_t reply,
  input wire logic       host_alive,
  input wire logic       sw_out,
  input wire logic       sw_oe_n,
  input wire logic       rst_out,
  input wire logic       rst_oe_n,
  input wire logic       disp_blank,
  input wire logic       backlight_off,
  input wire logic       fan_hold,
  input wire logic       show_on,
  input wire logic       show_off,
  input wire logic       show_reset,
  input wire logic [7:0] stat_mask,
  input wire logic [7:0] stat_wdt
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  a_pwr_reply: assert property (
    cmd.valid && cmd.ptype == CMD_PWR && cmd.len inside {2'd1, 2'd2}
    |=> reply.valid && reply.ptype == 8'h5C && stat_mask == $past(cmd.d0)) else $error("power command not taken");
  a_wdt_load: assert property (
    cmd.valid && cmd.ptype == CMD_WDT && cmd.len == 2'd1
    |=> reply.valid && reply.ptype == 8'h5D && stat_wdt == $past(cmd.d0)) else $error("watchdog not loaded");
  a_no_spurious: assert property (!cmd.valid |=> !reply.valid) else $error("reply without command");
  a_wdt_step: assert property (
    stat_wdt != 8'h00 && !cmd.valid |=> stat_wdt == $past(stat_wdt) || stat_wdt + 8'h01 == $past(stat_wdt))
    else $error("watchdog count jumped");
  a_blank_down: assert property (
    stat_mask[B_BLANK] && !host_alive |-> disp_blank && backlight_off) else $error("display not blanked");
  a_fan_keep: assert property (fan_hold == !host_alive) else $error("fan hold wrong");
  a_sw_level: assert property (
    !stat_mask[B_SENSE] && !sw_oe_n |-> sw_out == stat_mask[B_PWR_INV]) else $error("switch level wrong");
  a_rst_level: assert property (
    !stat_mask[B_SENSE] && !rst_oe_n |-> rst_out == stat_mask[B_RST_INV]) else $error("restart level wrong");
  a_switch_msg: assert property (!sw_oe_n |-> show_on || show_off) else $error("no message during pulse");
  a_reset_msg: assert property (!rst_oe_n |-> show_reset) else $error("no reset message");
endmodule
bind apw_top apw_properties chk_u (.sys_clk, .nrst, .cmd, .reply, .host_alive, .sw_out, .sw_oe_n, .rst_out,
  .rst_oe_n, .disp_blank, .backlight_off, .fan_hold, .show_on, .show_off, .show_reset, .stat_mask, .stat_wdt);
`default_nettype wire

// ==== tb/atx_power_switch_watchdog_test.sv ====
// bench for the power switch block against an integer model
`timescale 1ns/1ps
`default_nettype none
module atx_power_switch_watchdog_test;
  import apw_pkg::*;
  localparam int DIV = 4;
  logic       sys_clk, nrst, key_confirm, key_cancel, power_good, module_restart;
  logic       host_alive, sw_in, sw_out, sw_oe_n, rst_in, rst_out, rst_oe_n, disp_blank;
  logic [7:0] stat_mask, stat_wdt;
  apw_cmd_t   cmd;
  apw_reply_t reply;
  int         num_errors = 0, tests_run = 0, cyc = 0, seed = 96722, n, w, restarts = 0;
  int         exp_mask = 0, exp_wdt = 0, lvl = 0;

  apw_top #(.TICK_DIV(DIV)) dut_u (.sys_clk, .nrst, .cmd, .reply, .key_confirm, .key_cancel, .host_alive,
    .sw_in, .sw_out, .sw_oe_n, .rst_in, .rst_out, .rst_oe_n, .disp_blank, .backlight_off(), .fan_hold(),
    .show_on(), .show_off(), .show_reset(), .module_restart, .stat_mask, .stat_wdt);
  apw_host_model host_u (.sw_out, .sw_oe_n, .rst_out, .rst_oe_n, .power_good, .host_alive, .sw_in, .rst_in);

  task automatic conclude();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input int e);
    tests_run++;
    if (seen !== 8'(e)) begin
      num_errors++;
      $display("mismatch %s expected %0d seen %0d", what, e, seen);
    end
  endtask

  // pulse widths carry two ticks of phase slack
  task automatic check_len(input string what, input int seen, input int e);
    tests_run++;
    if (seen < e - 2 * DIV || seen > e + 2 * DIV) begin
      num_errors++;
      $display("mismatch %s expected %0d seen %0d", what, e, seen);
    end
  endtask

  task automatic send(input logic [7:0] t, input logic [1:0] l, input logic [7:0] a, input logic [7:0] b);
    bit ok;
    ok = (t == CMD_PWR && l inside {2'd1, 2'd2}) || (t == CMD_WDT && l == 2'd1);
    cmd <= '{1'b1, t, l, a, b};
    @(posedge sys_clk);
    cmd.valid <= 1'b0;
    if (ok && t == CMD_PWR) exp_mask = a;
    if (ok && t == CMD_WDT) exp_wdt = a;
    #1;
    check("reply", reply.valid ? reply.ptype : 8'h00, ok ? t | 8'h40 : 0);
    check("mask", stat_mask, exp_mask);
    check("count", stat_wdt, exp_wdt);
    @(posedge sys_clk);
  endtask

  // wait for a line to be driven, then count its driven cycles
  task automatic measure(input bit rst_line, input int lim);
    w = 0;
    for (n = 0; n < lim && (rst_line ? rst_oe_n : sw_oe_n) !== 1'b0; n++) @(posedge sys_clk);
    while ((rst_line ? rst_oe_n : sw_oe_n) === 1'b0 && w < lim) begin
      w++;
      lvl = rst_line ? rst_out : sw_out;
      @(posedge sys_clk);
    end
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (module_restart === 1'b1) restarts++;
    if (cyc > 12000) begin
      num_errors++;
      conclude();
    end
  end

  initial begin
    cmd = '0; key_confirm = 1'b0; key_cancel = 1'b0; power_good = 1'b0; nrst = 1'b0;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    #1;
    check("idle switch", sw_oe_n, 1);
    @(posedge sys_clk);
    repeat (8) send(CMD_PWR ^ 8'($random(seed) & 2), 2'($random(seed)), 8'($random(seed)), 8'h02);
    send(CMD_PWR, 2'd2, 8'hF4, 8'h02);
    check("blank", disp_blank, 1);
    key_confirm <= 1'b1;
    measure(0, 300);
    key_confirm <= 1'b0;
    check_len("on pulse", w, 2 * DIV);
    repeat (8) @(posedge sys_clk);
    check("restarts", restarts, 1);
    send(CMD_PWR, 2'd2, 8'hF4, 8'h02);
    power_good <= 1'b1;
    repeat (8) @(posedge sys_clk);
    check("restarts", restarts, 2);
    send(CMD_PWR, 2'd2, 8'hF4, 8'h02);
    key_cancel <= 1'b1;
    measure(0, 2000);
    key_cancel <= 1'b0;
    check_len("off pulse", w, (2 + 160) * DIV);
    send(CMD_WDT, 2'd1, 8'h02, 8'h00);
    repeat (100) @(posedge sys_clk);
    send(CMD_WDT, 2'd1, 8'h02, 8'h00);
    measure(1, 600);
    exp_wdt = 0;
    check_len("watchdog pulse", w, 32 * DIV);
    measure(1, 600);
    check_len("second pulse", w, 0);
    send(CMD_WDT, 2'd1, 8'h03, 8'h00);
    send(CMD_WDT, 2'd1, 8'h00, 8'h00);
    measure(1, 600);
    check_len("disabled pulse", w, 0);
    send(CMD_PWR, 2'd1, 8'hF5, 8'h00);
    key_confirm <= 1'b1;
    measure(1, 1000);
    key_confirm <= 1'b0;
    check_len("reset pulse", w, 32 * DIV);
    check("sense level", 8'(lvl), 0);
    repeat (8) @(posedge sys_clk);
    check("restarts", restarts, 3);
    conclude();
  end
endmodule
`default_nettype wire
